// [design/haptic_global_control.sv]
// Purpose: Global control registers, playback arbitration and output guard of the haptic driver
// Assumes: Pins synchronous to clk; drive levels given in 1/128 of supply
// Notes:   Playback source logic is reduced to a request/done handshake
`timescale 1ns/1ps
`include "haptic_params.svh"
module haptic_global_control #(
	parameter int GUARD_UNIT_CYC = `CYC_GUARD_UNIT,
	parameter int MEM_DEPTH      = 3072
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  scl,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	input  wire logic                  pin_event_input_one,
	output logic                       interrupt_out_low,
	output logic                       shared_pin_oe,
	input  wire logic                  irq_event,
	input  wire logic                  soft_launch_req,
	input  wire logic                  play_done,
	input  wire logic [6:0]            drive_out_pos,
	input  wire logic [6:0]            drive_out_neg,
	output logic                       drive_enable,
	output logic                       drive_pull_low,
	output logic                       chip_active,
	output logic                       module_clk_enable,
	output logic                       fir_filter_enable,
	output logic                       supply_comp_hw,
	output logic [2:0]                 sense_gain,
	output logic                       sample_tick,
	output haptic_pkg::glb_state_t     glb_state
);
	import haptic_pkg::*;

	initial begin
		if (GUARD_UNIT_CYC < 1 || GUARD_UNIT_CYC > 65535) $error("GUARD_UNIT_CYC out of range");
	end

	reg_access_if rb ();

	logic [7:0]  startup_delay_ff, priority_ff, sysctl1_ff, sysctl2_ff, gain_ff, guard_ff;
	logic [3:0]  addr_hi_ff;
	logic [7:0]  addr_lo_ff;
	play_state_t pst_ff;
	play_src_t   src_ff;
	glb_state_t  glb_ff;
	logic [10:0] rate_cnt_ff;
	logic [8:0]  s48_cnt_ff;
	logic [7:0]  dly_cnt_ff;
	logic [7:0]  brk_cnt_ff;
	logic [15:0] gu_cnt_ff;
	logic [6:0]  gu_units_ff;
	logic        trip_ff, pin_ff, tick_ff, active_ff, pin_oe_ff;
	logic [7:0]  mem_rdata;

	i2c_reg_slave u_slave (
		.clk     (clk),
		.sys_rst (sys_rst),
		.scl     (scl),
		.sda_in  (sda_in),
		.sda_oe  (sda_oe),
		.bus     (rb.master)
	);

	wire [11:0] mem_addr = {addr_hi_ff, addr_lo_ff};
	wire        wr_data  = rb.wr_stb && (rb.addr == `OFS_MEM_DATA);
	wire        rd_data  = rb.rd_stb && (rb.addr == `OFS_MEM_DATA);

	wave_memory #(.DEPTH(MEM_DEPTH)) u_mem (
		.clk   (clk),
		.we    (wr_data),
		.addr  (mem_addr),
		.wdata (rb.wdata),
		.rdata (mem_rdata)
	);

	// Read mux
	always_comb begin
		case (rb.addr)
		`OFS_STARTUP_DELAY: rb.rdata = startup_delay_ff;
		`OFS_PRIORITY:      rb.rdata = priority_ff;
		`OFS_STATE_READ:    rb.rdata = {4'h0, glb_ff};
		`OFS_MEM_ADDR_HIGH: rb.rdata = {4'h0, addr_hi_ff};
		`OFS_MEM_ADDR_LOW:  rb.rdata = addr_lo_ff;
		`OFS_MEM_DATA:      rb.rdata = mem_rdata;
		`OFS_SYSCTRL_ONE:   rb.rdata = sysctl1_ff;
		`OFS_SYSCTRL_TWO:   rb.rdata = sysctl2_ff;
		`OFS_SENSE_GAIN:    rb.rdata = gain_ff;
		`OFS_OUTPUT_GUARD:  rb.rdata = guard_ff;
		default:            rb.rdata = 8'h00;
		endcase
	end

	wire wr_dly  = rb.wr_stb && (rb.addr == `OFS_STARTUP_DELAY);
	wire wr_pri  = rb.wr_stb && (rb.addr == `OFS_PRIORITY);
	wire wr_hi   = rb.wr_stb && (rb.addr == `OFS_MEM_ADDR_HIGH);
	wire wr_lo   = rb.wr_stb && (rb.addr == `OFS_MEM_ADDR_LOW);
	wire wr_s1   = rb.wr_stb && (rb.addr == `OFS_SYSCTRL_ONE);
	wire wr_s2   = rb.wr_stb && (rb.addr == `OFS_SYSCTRL_TWO);
	wire wr_gain = rb.wr_stb && (rb.addr == `OFS_SENSE_GAIN);
	wire wr_grd  = rb.wr_stb && (rb.addr == `OFS_OUTPUT_GUARD);

	wire [11:0] nxt_mem_addr = mem_addr + 12'h001;
	wire        mem_step     = wr_data | rd_data;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			startup_delay_ff <= `RST_STARTUP_DELAY;
			priority_ff      <= `RST_PRIORITY;
			sysctl1_ff       <= `RST_SYSCTRL_ONE;
			sysctl2_ff       <= `RST_SYSCTRL_TWO;
			gain_ff          <= `RST_SENSE_GAIN;
			guard_ff         <= `RST_OUTPUT_GUARD;
			addr_hi_ff       <= 4'h0;
			addr_lo_ff       <= 8'h00;
		end else begin
			if (wr_dly)  startup_delay_ff <= rb.wdata;
			if (wr_pri)  priority_ff      <= rb.wdata;
			if (wr_s1)   sysctl1_ff       <= rb.wdata;
			if (wr_s2)   sysctl2_ff       <= rb.wdata;
			if (wr_gain) gain_ff          <= rb.wdata;
			if (wr_grd)  guard_ff         <= rb.wdata;
			if (mem_step) begin
				addr_hi_ff <= nxt_mem_addr[11:8];
				addr_lo_ff <= nxt_mem_addr[7:0];
			end else begin
				if (wr_hi) addr_hi_ff <= rb.wdata[3:0];
				if (wr_lo) addr_lo_ff <= rb.wdata;
			end
		end
	end

	// Wake and standby act on the write itself; standby wins if both are set
	wire wake_wr    = wr_s2 && rb.wdata[`BIT_WAKE];
	wire standby_wr = wr_s2 && rb.wdata[`BIT_STANDBY];
	wire pin_is_trig = ~sysctl2_ff[`BIT_PIN_SELECT];

	// Arbitration
	wire [1:0] soft_rank = priority_ff[7:6];
	wire [1:0] pin_rank  = priority_ff[1:0];
	wire pin_req  = pin_is_trig && pin_event_input_one && !pin_ff;
	// Pin beats soft at equal rank: fixed default ordering
	wire pin_over_soft = (pin_rank >= soft_rank);
	wire busy          = (pst_ff != PB_IDLE);
	wire take_pin  = pin_req && (!busy || (src_ff == SRC_SOFT && pin_over_soft)) &&
	                 !(soft_launch_req && !pin_over_soft && !busy);
	wire take_soft = soft_launch_req && !take_pin &&
	                 (!busy || (src_ff == SRC_PIN && !pin_over_soft));
	wire launch    = (take_pin || take_soft) && active_ff && !standby_wr;

	// Sample timing
	wire [10:0] rate_cyc = (sysctl2_ff[1:0] == 2'b00) ? 11'(`CYC_24K) :
	                       (sysctl2_ff[1:0] == 2'b01) ? 11'(`CYC_48K) : 11'(`CYC_12K);
	wire rate_wrap = (rate_cnt_ff >= rate_cyc - 11'h001);
	wire s48_wrap  = (s48_cnt_ff == 9'(`CYC_48K - 1));
	wire dly_done  = (dly_cnt_ff >= startup_delay_ff);

	// Guard: a zero guard time trips on the first over-level cycle
	wire over_lvl  = (drive_out_pos >= `GUARD_LEVEL) || (drive_out_neg >= `GUARD_LEVEL);
	wire guard_on  = guard_ff[`BIT_GUARD_EN] && (pst_ff == PB_DRIVE);
	wire gu_wrap   = (gu_cnt_ff == 16'(GUARD_UNIT_CYC - 1));
	wire gu_expire = (gu_units_ff >= guard_ff[6:0]);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pst_ff <= PB_IDLE; src_ff <= SRC_NONE; glb_ff <= GLB_STANDBY;
			s48_cnt_ff <= 9'h000; dly_cnt_ff <= 8'h00; brk_cnt_ff <= 8'h00;
		end else begin
			s48_cnt_ff <= (pst_ff != PB_DELAY || s48_wrap || launch) ? 9'h000 : s48_cnt_ff + 9'h001;
			if (standby_wr || !active_ff) begin
				pst_ff <= PB_IDLE; src_ff <= SRC_NONE; glb_ff <= GLB_STANDBY;
			end else if (launch) begin
				pst_ff     <= PB_DELAY;
				src_ff     <= take_pin ? SRC_PIN : SRC_SOFT;
				glb_ff     <= take_pin ? GLB_TRIG : GLB_MEMORY;
				dly_cnt_ff <= 8'h00;
			end else begin
				case (pst_ff)
				PB_IDLE:  glb_ff <= GLB_STANDBY;
				PB_DELAY: begin
					if (dly_done) pst_ff <= PB_DRIVE;
					else if (s48_wrap) dly_cnt_ff <= dly_cnt_ff + 8'h01;
				end
				PB_DRIVE: if (play_done) begin
					pst_ff <= PB_BRAKE; glb_ff <= GLB_BRAKE; src_ff <= SRC_NONE; brk_cnt_ff <= 8'h00;
				end
				PB_BRAKE: begin
					brk_cnt_ff <= brk_cnt_ff + 8'h01;
					if (brk_cnt_ff == 8'(`CYC_BRAKE - 1)) begin
						pst_ff <= PB_IDLE; glb_ff <= GLB_STANDBY;
					end
				end
				default: pst_ff <= PB_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gu_cnt_ff <= 16'h0000; gu_units_ff <= 7'h00; trip_ff <= 1'b0;
		end else if (!guard_on || !over_lvl || launch) begin
			gu_cnt_ff <= 16'h0000; gu_units_ff <= 7'h00;
			if (pst_ff != PB_DRIVE || launch) trip_ff <= 1'b0;
		end else begin
			// Latched until the drive phase ends, so the pull-down cannot chatter
			if (gu_expire) trip_ff <= 1'b1;
			gu_cnt_ff <= gu_wrap ? 16'h0000 : gu_cnt_ff + 16'h0001;
			if (gu_wrap && !gu_expire) gu_units_ff <= gu_units_ff + 7'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			active_ff <= 1'b0; pin_ff <= 1'b0; rate_cnt_ff <= 11'h000; tick_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			if (standby_wr) active_ff <= 1'b0;
			else if (wake_wr) active_ff <= 1'b1;
			pin_ff      <= pin_event_input_one;
			rate_cnt_ff <= rate_wrap ? 11'h000 : rate_cnt_ff + 11'h001;
			tick_ff     <= rate_wrap;
			pin_oe_ff   <= !pin_is_trig && irq_event;
		end
	end

	assign sda_out           = 1'b0;
	assign interrupt_out_low = 1'b0;
	assign shared_pin_oe     = pin_oe_ff;
	assign drive_enable      = (pst_ff == PB_DRIVE) && !trip_ff;
	assign drive_pull_low    = trip_ff;
	assign chip_active       = active_ff;
	assign module_clk_enable = sysctl1_ff[`BIT_CLK_GATE];
	assign fir_filter_enable = sysctl1_ff[`BIT_FIR_EN];
	assign supply_comp_hw    = sysctl1_ff[`BIT_SUPPLY_HW];
	assign sense_gain        = gain_ff[2:0];
	assign sample_tick       = tick_ff;
	assign glb_state         = glb_ff;
endmodule

// [design/haptic_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the global control group
// Assumes: 20 MHz core clock
// Notes:   Register offsets are the on-wire 8-bit register pointer values
`ifndef HAPTIC_PARAMS_SVH
`define HAPTIC_PARAMS_SVH

`define OFS_STARTUP_DELAY  8'h3C
`define OFS_PRIORITY       8'h3E
`define OFS_STATE_READ     8'h3F
`define OFS_MEM_ADDR_HIGH  8'h40
`define OFS_MEM_ADDR_LOW   8'h41
`define OFS_MEM_DATA       8'h42
`define OFS_SYSCTRL_ONE    8'h43
`define OFS_SYSCTRL_TWO    8'h44
`define OFS_SENSE_GAIN     8'h49
`define OFS_OUTPUT_GUARD   8'h4C

`define RST_STARTUP_DELAY  8'h04
`define RST_PRIORITY       8'h1B
`define RST_SYSCTRL_ONE    8'h04
`define RST_SYSCTRL_TWO    8'h28
`define RST_SENSE_GAIN     8'h14
`define RST_OUTPUT_GUARD   8'hA0

`define BIT_SUPPLY_HW      7
`define BIT_CLK_GATE       3
`define BIT_FIR_EN         2
`define BIT_WAKE           7
`define BIT_STANDBY        6
`define BIT_PIN_SELECT     3
`define BIT_GUARD_EN       7
`define GUARD_LEVEL        7'h7C

`define CLK_HZ             20000000
`define RATE_48K_HZ        48000
`define RATE_24K_HZ        24000
`define RATE_12K_HZ        12000
`define GUARD_UNIT_HZ      3000
`define CYC_48K            ((`CLK_HZ + `RATE_48K_HZ - 1) / `RATE_48K_HZ)
`define CYC_24K            ((`CLK_HZ + `RATE_24K_HZ - 1) / `RATE_24K_HZ)
`define CYC_12K            ((`CLK_HZ + `RATE_12K_HZ - 1) / `RATE_12K_HZ)
`define CYC_GUARD_UNIT     ((`CLK_HZ + `GUARD_UNIT_HZ - 1) / `GUARD_UNIT_HZ)
`define CYC_BRAKE          200
`define I2C_DEV_ADDR       7'h58

`endif

// [design/haptic_pkg.sv]
// Purpose: Shared types of the global control group
// Assumes: Nothing beyond the parameter header
// Notes:   State codes of the readback field are the hardware encodings
package haptic_pkg;
	typedef enum logic [3:0] {
		GLB_STANDBY = 4'h0,
		GLB_CONT    = 4'h6,
		GLB_MEMORY  = 4'h7,
		GLB_STREAM  = 4'h8,
		GLB_TRIG    = 4'h9,
		GLB_BRAKE   = 4'hB
	} glb_state_t;

	typedef enum logic [3:0] {
		PB_IDLE  = 4'b0001,
		PB_DELAY = 4'b0010,
		PB_DRIVE = 4'b0100,
		PB_BRAKE = 4'b1000
	} play_state_t;

	typedef enum logic [8:0] {
		I2_IDLE  = 9'b000000001,
		I2_ADDR  = 9'b000000010,
		I2_ACK_A = 9'b000000100,
		I2_REG   = 9'b000001000,
		I2_ACK_R = 9'b000010000,
		I2_WDATA = 9'b000100000,
		I2_ACK_W = 9'b001000000,
		I2_RDATA = 9'b010000000,
		I2_RACK  = 9'b100000000
	} i2c_state_t;

	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_SOFT = 2'h1,
		SRC_PIN  = 2'h2
	} play_src_t;
endpackage

// [design/reg_access_if.sv]
// Purpose: Register access strobes between the serial slave and the register bank
// Assumes: One clock domain
// Notes:   Strobes are one-cycle pulses; rdata is combinational from addr
`timescale 1ns/1ps
interface reg_access_if;
	logic       wr_stb;
	logic       rd_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport slave  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// [design/i2c_reg_slave.sv]
// Purpose: Serial two-wire slave turning bus transfers into register strobes
// Assumes: scl and sda_in synchronous to clk, bus far slower than clk
// Notes:   Pointer auto-increments except on the memory data port
`timescale 1ns/1ps
`include "haptic_params.svh"
module i2c_reg_slave #(
	parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR
) (
	input  wire logic  clk,
	input  wire logic  sys_rst,
	input  wire logic  scl,
	input  wire logic  sda_in,
	output logic       sda_oe,
	reg_access_if.master bus
);
	import haptic_pkg::*;

	i2c_state_t st_ff;
	logic       scl_ff, sda_ff, rw_ff, oe_ff, wr_ff, rd_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff, tx_ff, ptr_ff;

	wire scl_rise  = scl & ~scl_ff;
	wire scl_fall  = ~scl & scl_ff;
	wire got_start = scl & scl_ff & sda_ff & ~sda_in;
	wire got_stop  = scl & scl_ff & ~sda_ff & sda_in;
	wire byte_done = (cnt_ff == 4'h8);
	wire addr_hit  = (sh_ff[7:1] == DEV_ADDR);
	// Streaming to the data port must keep the pointer on it
	wire [7:0] nxt_ptr = (ptr_ff == `OFS_MEM_DATA) ? ptr_ff : ptr_ff + 8'h01;

	assign sda_oe     = oe_ff;
	assign bus.wr_stb = wr_ff;
	assign bus.rd_stb = rd_ff;
	assign bus.addr   = ptr_ff;
	assign bus.wdata  = sh_ff;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= I2_IDLE; scl_ff <= 1'b1; sda_ff <= 1'b1; rw_ff <= 1'b0; oe_ff <= 1'b0;
			wr_ff <= 1'b0; rd_ff <= 1'b0; cnt_ff <= 4'h0; sh_ff <= 8'h00; tx_ff <= 8'h00;
			ptr_ff <= 8'h00;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda_in;
			wr_ff  <= 1'b0;
			rd_ff  <= 1'b0;
			// Step only after the read strobe, so the strobe names the register that was read
			if (rd_ff) ptr_ff <= nxt_ptr;
			if (got_start) begin
				st_ff <= I2_ADDR; cnt_ff <= 4'h0; oe_ff <= 1'b0;
			end else if (got_stop) begin
				st_ff <= I2_IDLE; oe_ff <= 1'b0;
			end else if (scl_rise) begin
				sh_ff  <= {sh_ff[6:0], sda_in};
				cnt_ff <= cnt_ff + 4'h1;
				if (st_ff == I2_RACK && sda_in) st_ff <= I2_IDLE;
			end else if (scl_fall) begin
				case (st_ff)
				I2_ADDR: if (byte_done) begin
					st_ff <= addr_hit ? I2_ACK_A : I2_IDLE; oe_ff <= addr_hit; rw_ff <= sh_ff[0];
				end
				I2_ACK_A, I2_RACK: begin
					cnt_ff <= 4'h0;
					if (rw_ff) begin
						st_ff <= I2_RDATA; tx_ff <= bus.rdata; oe_ff <= ~bus.rdata[7];
						rd_ff <= 1'b1;
					end else begin
						st_ff <= I2_REG; oe_ff <= 1'b0;
					end
				end
				I2_REG: if (byte_done) begin
					st_ff <= I2_ACK_R; oe_ff <= 1'b1; ptr_ff <= sh_ff;
				end
				I2_ACK_R, I2_ACK_W: begin
					st_ff <= I2_WDATA; oe_ff <= 1'b0; cnt_ff <= 4'h0;
					if (st_ff == I2_ACK_W) ptr_ff <= nxt_ptr;
				end
				I2_WDATA: if (byte_done) begin
					st_ff <= I2_ACK_W; oe_ff <= 1'b1; wr_ff <= 1'b1;
				end
				I2_RDATA: if (byte_done) begin
					st_ff <= I2_RACK; oe_ff <= 1'b0;
				end else begin
					tx_ff <= {tx_ff[6:0], 1'b0}; oe_ff <= ~tx_ff[6];
				end
				default: st_ff <= I2_IDLE;
				endcase
			end
		end
	end
endmodule

// [design/wave_memory.sv]
// Purpose: Waveform byte store behind the indirect data port
// Assumes: Single port, write strobe one cycle
// Notes:   Addresses at or above DEPTH read zero and drop writes
`timescale 1ns/1ps
module wave_memory #(
	parameter int DEPTH = 3072
) (
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	initial begin
		if (DEPTH < 1 || DEPTH > 4096) $error("DEPTH out of range");
	end

	logic [7:0] mem [0:DEPTH-1];
	wire        in_range = (32'(addr) < DEPTH);

	assign rdata = in_range ? mem[addr] : 8'h00;

	// No reset: contents are loaded by software after power-up
	always_ff @(posedge clk) begin
		if (we && in_range) mem[addr] <= wdata;
	end
endmodule

// [bench/i2c_host_model.sv]
// Purpose: Two-wire host issuing single-byte register writes and reads
// Assumes: Lines change on falling clk edges, four clocks per quarter bit
// Notes:   Data line has a pull-up, so a released line reads high
`timescale 1ns/1ps
`include "haptic_params.svh"
module i2c_host_model (
	input  wire logic clk,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_in
);
	logic       pull;
	logic       nak;
	logic [7:0] dev;
	assign sda_in = ~(pull | sda_oe);
	initial begin
		scl = 1'h1;
		pull = 1'h0;
		nak = 1'h0;
		dev = {`I2C_DEV_ADDR, 1'h0};
	end
	task q;
		repeat (4) @(negedge clk);
	endtask
	task bit_io(input logic b, output logic r);
		pull = ~b;
		q;
		scl = 1'h1;
		q;
		r = sda_in;
		q;
		scl = 1'h0;
		q;
	endtask
	task start;
		pull = 1'h0;
		q;
		scl = 1'h1;
		q;
		pull = 1'h1;
		q;
		scl = 1'h0;
		q;
	endtask
	task stop;
		pull = 1'h1;
		q;
		scl = 1'h1;
		q;
		pull = 1'h0;
		q;
	endtask
	// Host always releases the ninth bit; a single-byte read ends in a nack
	task xbyte(input logic [7:0] d, input logic own, output logic [7:0] r);
		logic k;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'h1, k);
		if (own)
			nak = nak | k;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		nak = 1'h0;
		start;
		xbyte(dev, 1'h1, r);
		xbyte(a, 1'h1, r);
		xbyte(d, 1'h1, r);
		stop;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		nak = 1'h0;
		start;
		xbyte(dev, 1'h1, d);
		xbyte(a, 1'h1, d);
		start;
		xbyte(dev | 8'h01, 1'h1, d);
		xbyte(8'hFF, 1'h0, d);
		stop;
	endtask
endmodule

// [bench/haptic_global_control_chk.sv]
// Purpose: Concurrent checks on the global control ports
// Assumes: One clock, asynchronous active-high reset
// Notes:   Tick gap is bounded by the slowest rate, since a rate change may lengthen one gap
`timescale 1ns/1ps
`include "haptic_params.svh"
module haptic_global_control_chk #(
	parameter int GUARD_UNIT_CYC = `CYC_GUARD_UNIT
) (
	input wire logic                   clk,
	input wire logic                   sys_rst,
	input wire logic                   irq_event,
	input wire logic                   shared_pin_oe,
	input wire logic [6:0]             drive_out_pos,
	input wire logic [6:0]             drive_out_neg,
	input wire logic                   drive_enable,
	input wire logic                   drive_pull_low,
	input wire logic                   chip_active,
	input wire logic                   module_clk_enable,
	input wire logic                   fir_filter_enable,
	input wire logic                   supply_comp_hw,
	input wire logic                   sample_tick,
	input wire haptic_pkg::glb_state_t glb_state
);
	import haptic_pkg::*;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [11:0] gap_ff;
	logic        hot;
	assign hot = (drive_out_pos >= `GUARD_LEVEL) || (drive_out_neg >= `GUARD_LEVEL);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			gap_ff <= 12'h000;
		else
			gap_ff <= sample_tick ? 12'h000 : gap_ff + 12'h001;
	end
	a_trip_kills_drive: assert property (drive_pull_low |=> !drive_enable)
		else $error("drive enabled while guard tripped");
	a_trip_needs_level: assert property ($rose(drive_pull_low) |-> $past(hot))
		else $error("guard tripped below level");
	a_irq_cause: assert property (shared_pin_oe |-> $past(irq_event))
		else $error("shared pin pulled without request");
	a_tick_bound: assert property (gap_ff < 12'(`CYC_12K))
		else $error("sample tick missing");
	a_state_codes: assert property (glb_state inside {GLB_STANDBY, GLB_CONT, GLB_MEMORY,
		GLB_STREAM, GLB_TRIG, GLB_BRAKE}) else $error("illegal state code");
	a_drive_in_play: assert property (drive_enable |-> glb_state inside {GLB_MEMORY, GLB_TRIG})
		else $error("drive outside playback");
	a_brake_hold: assert property (glb_state == GLB_BRAKE && $past(glb_state) != GLB_BRAKE
		|=> (glb_state == GLB_BRAKE || !chip_active) [*8]) else $error("brake cut short");
	a_standby_quiet: assert property (!chip_active [*2] |-> !drive_enable)
		else $error("drive while in standby");
	a_reset_bits: assert property ($fell(sys_rst) |-> fir_filter_enable && !module_clk_enable
		&& !supply_comp_hw && !chip_active) else $error("control bits wrong after reset");
	c_trip: cover property ($rose(drive_pull_low));
	c_preempt: cover property ($past(glb_state) == GLB_MEMORY && glb_state == GLB_TRIG);
	c_irq: cover property ($rose(shared_pin_oe));
endmodule

bind haptic_global_control haptic_global_control_chk #(.GUARD_UNIT_CYC(GUARD_UNIT_CYC)) u_chk (
	.clk, .sys_rst, .irq_event, .shared_pin_oe, .drive_out_pos, .drive_out_neg, .drive_enable,
	.drive_pull_low, .chip_active, .module_clk_enable, .fir_filter_enable, .supply_comp_hw,
	.sample_tick, .glb_state
);

// [bench/tb.sv]
// Purpose: Self-checking bench for the global control group
// Assumes: Inputs change on falling clk edges
// Notes:   Guard unit shortened to four clocks to keep the run brief
`timescale 1ns/1ps
`include "haptic_params.svh"
module tb;
	import haptic_pkg::*;
	localparam int L = 4 * `CYC_48K;
	localparam int G = 32 * 4;
	logic       clk, sys_rst, scl, sda_in, sda_oe, pin_event_input_one, shared_pin_oe, irq_event;
	logic       soft_launch_req, play_done, drive_enable, drive_pull_low, chip_active;
	logic       module_clk_enable, fir_filter_enable, supply_comp_hw, sample_tick;
	logic [6:0] drive_out_pos, drive_out_neg;
	logic [2:0] sense_gain;
	logic [7:0] d;
	glb_state_t glb_state;
	int         error_cnt, tests_run, cnt, per;
	logic [7:0] offs [10] = '{8'h3C, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h43, 8'h44, 8'h49, 8'h4C, 8'h50};
	logic [7:0] rsts [10] = '{8'h04, 8'h1B, 8'h00, 8'h00, 8'h00, 8'h04, 8'h28, 8'h14, 8'hA0, 8'h00};
	haptic_global_control #(.GUARD_UNIT_CYC(4)) DUT (.clk, .sys_rst, .scl, .sda_in, .sda_out(), .sda_oe,
		.pin_event_input_one, .interrupt_out_low(), .shared_pin_oe, .irq_event, .soft_launch_req,
		.play_done, .drive_out_pos, .drive_out_neg, .drive_enable, .drive_pull_low, .chip_active,
		.module_clk_enable, .fir_filter_enable, .supply_comp_hw, .sense_gain, .sample_tick, .glb_state);
	i2c_host_model host (.clk, .sda_oe, .scl, .sda_in);
	initial clk = 1'h0;
	always #25 clk = ~clk;
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk($sformatf("register %h", a), 16'(e), 16'(d));
	endtask
	function logic sel(input int w);
		case (w)
			0: sel = sample_tick;
			1: sel = drive_enable;
			default: sel = drive_pull_low;
		endcase
	endfunction
	// Bounded wait; running out ends the run
	task wt(input int w, input logic v);
		cnt = 0;
		while (sel(w) !== v && cnt < 5000) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 5000) begin
			chk("wait bound", 16'h0000, 16'hFFFF);
			stop_test;
		end
	endtask
	task launch(input logic p, input glb_state_t e);
		if (p)
			pin_event_input_one = 1'h1;
		else
			soft_launch_req = 1'h1;
		repeat (2) @(negedge clk);
		pin_event_input_one = 1'h0;
		soft_launch_req = 1'h0;
		repeat (2) @(negedge clk);
		chk("glb_state", 16'(e), 16'(glb_state));
	endtask
	task rst;
		sys_rst = 1'h1;
		repeat (2) @(negedge clk);
		sys_rst = 1'h0;
		repeat (2) @(negedge clk);
	endtask
	initial begin
		{pin_event_input_one, irq_event, soft_launch_req, play_done} = 4'h0;
		drive_out_pos = 7'h00;
		drive_out_neg = 7'h00;
		error_cnt = 0;
		tests_run = 0;
		rst;
		for (int i = 0; i < 10; i++)
			rchk(offs[i], rsts[i]);
		chk("sense_gain", 16'h0004, 16'(sense_gain));
		host.dev = 8'hA0;
		host.wr(8'h3C, 8'h77);
		chk("nak", 16'h0001, 16'(host.nak));
		host.dev = {`I2C_DEV_ADDR, 1'h0};
		rchk(8'h3C, 8'h04);
		host.wr(8'h3F, 8'hFF);
		rchk(8'h3F, 8'h00);
		host.wr(8'h43, 8'h88);
		chk("control", 16'h0006, 16'({supply_comp_hw, module_clk_enable, fir_filter_enable}));
		rchk(8'h43, 8'h88);
		$display("test registers done");
		host.wr(8'h40, 8'h01);
		host.wr(8'h41, 8'hFF);
		host.wr(8'h42, 8'hA5);
		rchk(8'h40, 8'h02);
		rchk(8'h41, 8'h00);
		host.wr(8'h42, 8'h5A);
		host.wr(8'h41, 8'hFF);
		host.wr(8'h40, 8'h01);
		rchk(8'h42, 8'hA5);
		rchk(8'h42, 8'h5A);
		$display("test memory port done");
		for (int r = 0; r < 4; r++) begin
			host.wr(8'h44, 8'h80 | 8'(r));
			wt(0, 1'h1);
			wt(0, 1'h0);
			per = cnt;
			wt(0, 1'h1);
			chk("tick period", r == 0 ? 16'(`CYC_24K) : r == 1 ? 16'(`CYC_48K) : 16'(`CYC_12K), 16'(per + cnt));
		end
		chk("awake", 16'h0001, 16'(chip_active));
		$display("test rates done");
		launch(1'h0, GLB_MEMORY);
		wt(1, 1'h1);
		chk("start delay", 16'h0001, 16'(cnt >= L - 4 && cnt <= L + 4));
		launch(1'h1, GLB_TRIG);
		launch(1'h0, GLB_TRIG);
		wt(1, 1'h1);
		play_done = 1'h1;
		@(negedge clk);
		play_done = 1'h0;
		repeat (2) @(negedge clk);
		chk("brake", 16'(GLB_BRAKE), 16'(glb_state));
		repeat (190) @(negedge clk);
		chk("brake", 16'(GLB_BRAKE), 16'(glb_state));
		repeat (15) @(negedge clk);
		chk("idle", 16'(GLB_STANDBY), 16'(glb_state));
		host.wr(8'h3E, 8'hDB);
		launch(1'h0, GLB_MEMORY);
		launch(1'h1, GLB_TRIG);
		launch(1'h0, GLB_TRIG);
		host.wr(8'h44, 8'h40);
		chk("standby", 16'h0000, 16'({chip_active, glb_state}));
		host.wr(8'h44, 8'h80);
		host.wr(8'h3E, 8'hD9);
		launch(1'h1, GLB_TRIG);
		launch(1'h0, GLB_MEMORY);
		launch(1'h1, GLB_MEMORY);
		$display("test arbitration done");
		wt(1, 1'h1);
		drive_out_pos = 7'h7B;
		repeat (300) @(negedge clk);
		chk("guard low level", 16'h0000, 16'(drive_pull_low));
		drive_out_neg = 7'h7C;
		wt(2, 1'h1);
		chk("guard time", 16'h0001, 16'(cnt >= G - 3 && cnt <= G + 4));
		chk("drive cut", 16'h0000, 16'(drive_enable));
		drive_out_pos = 7'h00;
		drive_out_neg = 7'h00;
		// End the tripped playback so the pin test starts from standby
		play_done = 1'h1;
		@(negedge clk);
		play_done = 1'h0;
		host.wr(8'h44, 8'h80);
		chk("trip released", 16'h0000, 16'(drive_pull_low));
		irq_event = 1'h1;
		repeat (3) @(negedge clk);
		chk("pin as input", 16'h0000, 16'(shared_pin_oe));
		host.wr(8'h44, 8'h88);
		chk("pin as irq", 16'h0001, 16'(shared_pin_oe));
		irq_event = 1'h0;
		launch(1'h1, GLB_STANDBY);
		chk("pin released", 16'h0000, 16'(shared_pin_oe));
		$display("test guard and shared pin done");
		rst;
		rchk(8'h44, 8'h28);
		stop_test;
	end
	initial begin
		repeat (100000) @(posedge clk);
		chk("run length", 16'h0000, 16'hFFFF);
		stop_test;
	end
endmodule
